// ### bench/gpt_board.sv
// board model: resolves port pins from device drive and board drive
// assumes one clock; an undriven pin without pull-up toggles each cycle
`timescale 1ns/1ns
`default_nettype none
module gpt_board #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic [W-1:0] drv,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] pu,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    output logic [W-1:0] pin
);
    logic [W-1:0] last = '0;
    always_ff @(posedge aclk)
        last <= pin;
    always_comb
        for (int i = 0; i < W; i++)
            pin[i] = oe[i] ? drv[i] : ext_en[i] ? ext_val[i] : pu[i] ? 1'h1 : ~last[i];
endmodule // gpt_board
`default_nettype wire

// ### bench/gpt_ports_asserts.sv
// checker for the port block, bound to its top module
// assumes the single aclk domain and synchronous aresetn
`timescale 1ns/1ns
`default_nettype none
module gpt_ports_asserts
    import gpt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [gpt_pkg::P3_W-1:0] port_three_oe,
    input wire logic [gpt_pkg::P3_W-1:0] port_three_pullup_en,
    input wire logic tool_data_pin_oe,
    input wire logic tool_data_pin_pullup_en,
    input wire logic tool_attached,
    input wire logic tool_data_oe,
    input wire logic tool_data_in,
    input wire logic [gpt_pkg::P6_W-1:0] port_six_out,
    input wire logic [gpt_pkg::P6_W-1:0] port_six_oe,
    input wire logic interrupt_input_pin,
    input wire logic oscillator_select,
    input wire logic external_clock_select,
    input wire logic interrupt_request
);
    import gpt_pkg::*;
    logic [7:0] aw_q, next_aw;
    logic st_q, next_st, lock_q, next_lock;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // remembers a completed clock mode write
    always_comb
    begin
        next_aw = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_q;
        next_st = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : st_q;
        next_lock = lock_q | (s_axi_bvalid && aw_q == OFS_CLK_MODE && st_q);
    end
    always_ff @(posedge aclk)
    begin
        aw_q <= aresetn ? next_aw : 8'h00;
        st_q <= aresetn ? next_st : 1'h0;
        lock_q <= aresetn ? next_lock : 1'h0;
    end
    sequence wr_take;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence tool_held;
        (tool_attached && $stable(tool_data_oe))[*6];
    endsequence
    a_reset_idle: assert property (disable iff (1'h0) !aresetn |=>
        port_three_oe == '0 && !tool_data_pin_oe && port_six_oe == '0 && !oscillator_select)
        else $error("outputs not idle after reset");
    a_pullup_input: assert property ((port_three_pullup_en & port_three_oe) == '0)
        else $error("port three pull-up on a driven bit");
    a_four_pullup: assert property (!(tool_data_pin_pullup_en && tool_data_pin_oe))
        else $error("port four pull-up while driving");
    a_six_open_drain: assert property (port_six_out == '0)
        else $error("port six drives high");
    a_tool_drive: assert property (tool_held |-> tool_data_pin_oe == tool_data_oe)
        else $error("tool drive not on pin");
    a_tool_idle: assert property ((!tool_attached)[*6] |-> !tool_data_in)
        else $error("tool input active without tool");
    a_mode_locked: assert property (lock_q |=> $stable({oscillator_select, external_clock_select}))
        else $error("clock mode changed after lock");
    a_irq_follows: assert property ($stable(interrupt_input_pin)[*5] |-> interrupt_request == interrupt_input_pin)
        else $error("interrupt level not followed");
    a_write_answer: assert property (wr_take |-> ##[1:8] s_axi_bvalid)
        else $error("write not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_answer: assert property ($rose(s_axi_arready) |-> s_axi_rvalid)
        else $error("read data late");
endmodule // gpt_ports_asserts
bind gpt_ports gpt_ports_asserts gpt_ports_asserts_i (.*);
`default_nettype wire

// ### bench/tb_gpio_ports_three_to_thirteen.sv
// testbench for the port block: register access and pin checks
// assumes board models on ports three, four and six
`timescale 1ns/1ns
`default_nettype none
module tb_gpio_ports_three_to_thirteen;
    import gpt_pkg::*;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [5:0] port_three_in, port_three_out, port_three_oe, port_three_pullup_en, e3en = 0, e3v = 0;
    logic tool_data_pin_in, tool_data_pin_out, tool_data_pin_oe, tool_data_pin_pullup_en, tool_data_in;
    logic tool_attached = 0, tool_data_out = 0, tool_data_oe = 0, e4en = 0, e4v = 0;
    logic [1:0] port_six_in, port_six_out, port_six_oe, e6en = 0, e6v = 0;
    logic osc_in_pin = 0, osc_out_pin = 0, interrupt_input_pin = 0;
    logic oscillator_select, external_clock_select, interrupt_request;
    int checked = 0, bad_count = 0;
    gpt_ports gpt_ports_i (.*);
    gpt_board #(.W(6)) gpt_board_i (.aclk(aclk), .drv(port_three_out), .oe(port_three_oe),
        .pu(port_three_pullup_en), .ext_en(e3en), .ext_val(e3v), .pin(port_three_in));
    gpt_board #(.W(1)) gpt_board_p4_i (.aclk(aclk), .drv(tool_data_pin_out), .oe(tool_data_pin_oe),
        .pu(tool_data_pin_pullup_en), .ext_en(e4en), .ext_val(e4v), .pin(tool_data_pin_in));
    gpt_board #(.W(2)) gpt_board_p6_i (.aclk(aclk), .drv(port_six_out), .oe(port_six_oe),
        .pu(2'h3), .ext_en(e6en), .ext_val(e6v), .pin(port_six_in));
    always #5 aclk = ~aclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
        input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        chk(s_axi_bresp, er);
        s_axi_bready <= 0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY,
        input logic [31:0] m = 32'hFFFFFFFF);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata & m, e);
        chk(s_axi_rresp, er);
        s_axi_rready <= 0;
    endtask
    task automatic rst();
        aresetn <= 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1;
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        test_done();
    end
    // no serial, timer or two-wire unit drives these pins here
    initial
    begin
        rst();
        rc(OFS_P3_DIR, 32'h3F);
        rc(OFS_P4_DIR, 32'h1);
        rc(OFS_P6_DIR, 32'h3);
        rc(OFS_CLK_MODE, 32'h0);
        e3en <= 6'h3F;
        e3v <= 6'h15;
        wr(OFS_P3_DATA, 32'h2A);
        repeat (4) @(posedge aclk);
        rc(OFS_P3_DATA, 32'h15);
        chk(port_three_out, 32'h2A);
        wr(OFS_P3_DIR, 32'h30);
        repeat (4) @(posedge aclk);
        chk(port_three_oe, 32'h0F);
        rc(OFS_P3_DATA, 32'h1A);
        wr(OFS_P3_DATA, 32'h3F, 4'h0);
        rc(OFS_P3_DATA, 32'h1A);
        e3en <= 6'h00;
        wr(OFS_P3_DIR, 32'h3F);
        wr(OFS_P3_PU, 32'h05);
        repeat (4) @(posedge aclk);
        chk(port_three_pullup_en, 32'h05);
        rc(OFS_P3_DATA, 32'h05, RESP_OKAY, 32'h05);
        wr(OFS_P3_DIR, 32'h3E);
        repeat (2) @(posedge aclk);
        chk({port_three_pullup_en, port_three_oe}, 32'h101);
        wr(OFS_P4_DIR, 32'h0);
        wr(OFS_P4_DATA, 32'h1);
        repeat (2) @(posedge aclk);
        chk({tool_data_pin_oe, tool_data_pin_out}, 32'h3);
        wr(OFS_P4_DIR, 32'h1);
        wr(OFS_P4_PU, 32'h1);
        repeat (4) @(posedge aclk);
        chk({tool_data_pin_oe, tool_data_pin_pullup_en}, 32'h1);
        rc(OFS_P4_DATA, 32'h1);
        tool_attached <= 1;
        tool_data_oe <= 1;
        tool_data_out <= 1;
        repeat (8) @(posedge aclk);
        chk({tool_data_pin_oe, tool_data_pin_out}, 32'h3);
        tool_data_oe <= 0;
        e4en <= 1;
        e4v <= 1;
        repeat (8) @(posedge aclk);
        chk({tool_data_pin_oe, tool_data_in}, 32'h1);
        tool_attached <= 0;
        e4en <= 0;
        wr(OFS_P6_DATA, 32'h0);
        wr(OFS_P6_DIR, 32'h0);
        repeat (2) @(posedge aclk);
        chk({port_six_out, port_six_oe, port_six_in}, 32'h0C);
        wr(OFS_P6_DATA, 32'h2);
        repeat (2) @(posedge aclk);
        chk({port_six_oe, port_six_in}, 32'h6);
        rc(OFS_P6_DATA, 32'h2);
        wr(OFS_P6_DIR, 32'h3);
        repeat (4) @(posedge aclk);
        rc(OFS_P6_DATA, 32'h3);
        e6en <= 2'h3;
        e6v <= 2'h2;
        repeat (4) @(posedge aclk);
        rc(OFS_P6_DATA, 32'h2);
        osc_in_pin <= 1;
        osc_out_pin <= 1;
        interrupt_input_pin <= 1;
        repeat (6) @(posedge aclk);
        rc(OFS_P12_DATA, 32'h6);
        wr(OFS_P12_DATA, 32'h0, 4'hF, RESP_SLVERR);
        wr(OFS_CLK_MODE, 32'h1);
        rc(OFS_CLK_MODE, 32'h5);
        rc(OFS_P12_DATA, 32'h0);
        wr(OFS_CLK_MODE, 32'h2);
        rc(OFS_CLK_MODE, 32'h5);
        chk(oscillator_select, 32'h1);
        rc(OFS_P13_DATA, 32'h80);
        chk(interrupt_request, 32'h1);
        wr(OFS_P13_DATA, 32'h0, 4'hF, RESP_SLVERR);
        rc(8'h40, 32'h0, RESP_SLVERR);
        rst();
        chk(port_three_oe, 32'h0);
        wr(OFS_CLK_MODE, 32'h3);
        repeat (4) @(posedge aclk);
        rc(OFS_P12_DATA, 32'h2);
        chk({oscillator_select, external_clock_select}, 32'h3);
        test_done();
    end
endmodule // tb_gpio_ports_three_to_thirteen
`default_nettype wire

// ### verilog/gpt_pkg.sv
// package for the general-purpose port block: offsets, widths, reset values
// assumes an AXI4-Lite master with 32-bit data and byte addresses
// What this block and its software do
// [RULE1] port three bits: 1 input, 0 drives latch
// [RULE2] port three input pull-up per option bit
// [RULE3] reset puts port three into input mode
// [RULE4] software holds shared serial outputs high
// [RULE5] software leaves serial channel zero bits reset
// [RULE6] software keeps timer out two bits zero
// [RULE7] port four pin follows direction, optional pull-up
// [RULE8] reset puts port four into input mode
// [RULE9] attached tool owns port four pin
// [RULE10] port six outputs are open-drain only
// [RULE11] port six per-bit direction, input after reset
// [RULE12] software halts two-wire unit before port use
// [RULE13] port twelve pins never drive
// [RULE14] port twelve input gated by oscillator selection
// [RULE15] oscillator selection accepted once after reset
// [RULE16] oscillator use holds until next reset
// [RULE17] reset puts port twelve into input mode
// [RULE18] port thirteen pin seven is input only
// [RULE19] data read: pin if input, latch if output
// [RULE20] data write updates latch in any mode
package gpt_pkg;
    localparam int P3_W = 6;
    localparam int P4_W = 1;
    localparam int P6_W = 2;
    localparam logic [7:0] OFS_P3_DATA = 8'h00;
    localparam logic [7:0] OFS_P3_DIR = 8'h04;
    localparam logic [7:0] OFS_P3_PU = 8'h08;
    localparam logic [7:0] OFS_P4_DATA = 8'h0C;
    localparam logic [7:0] OFS_P4_DIR = 8'h10;
    localparam logic [7:0] OFS_P4_PU = 8'h14;
    localparam logic [7:0] OFS_P6_DATA = 8'h18;
    localparam logic [7:0] OFS_P6_DIR = 8'h1C;
    localparam logic [7:0] OFS_P12_DATA = 8'h20;
    localparam logic [7:0] OFS_CLK_MODE = 8'h24;
    localparam logic [7:0] OFS_P13_DATA = 8'h28;
    localparam int CLK_MODE_OSC_BIT = 0;
    localparam int CLK_MODE_EXT_BIT = 1;
    localparam int CLK_MODE_DONE_BIT = 2;
    localparam int P13_PIN_BIT = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [P3_W-1:0] P3_DIR_RST = 6'h3F;
    localparam logic [P4_W-1:0] P4_DIR_RST = 1'h1;
    localparam logic [P6_W-1:0] P6_DIR_RST = 2'h3;
endpackage

// ### verilog/gpt_ports.sv
// port logic for ports three, four, six, twelve and thirteen with AXI4-Lite registers
// assumes pins are synchronised here; pad wiring resolves enables outside
`timescale 1ns/1ns
`default_nettype none
module gpt_ports
    import gpt_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [gpt_pkg::P3_W-1:0] port_three_in,
    output logic [gpt_pkg::P3_W-1:0] port_three_out,
    output logic [gpt_pkg::P3_W-1:0] port_three_oe,
    output logic [gpt_pkg::P3_W-1:0] port_three_pullup_en,
    input wire logic tool_data_pin_in,
    output logic tool_data_pin_out,
    output logic tool_data_pin_oe,
    output logic tool_data_pin_pullup_en,
    input wire logic tool_attached,
    input wire logic tool_data_out,
    input wire logic tool_data_oe,
    output logic tool_data_in,
    input wire logic [gpt_pkg::P6_W-1:0] port_six_in,
    output logic [gpt_pkg::P6_W-1:0] port_six_out,
    output logic [gpt_pkg::P6_W-1:0] port_six_oe,
    input wire logic osc_in_pin,
    input wire logic osc_out_pin,
    input wire logic interrupt_input_pin,
    output logic oscillator_select,
    output logic external_clock_select,
    output logic interrupt_request
);
    import gpt_pkg::*;

    localparam int SYNC_W = P3_W + 1 + 1 + P6_W + 2 + 1;

    logic [P3_W-1:0] port_three_data, next_port_three_data;
    logic [P3_W-1:0] port_three_direction, next_port_three_direction;
    logic [P3_W-1:0] port_three_pullup_option, next_port_three_pullup_option;
    logic [P4_W-1:0] port_four_data, next_port_four_data;
    logic [P4_W-1:0] port_four_direction, next_port_four_direction;
    logic [P4_W-1:0] port_four_pullup_option, next_port_four_pullup_option;
    logic [P6_W-1:0] port_six_data, next_port_six_data;
    logic [P6_W-1:0] port_six_direction, next_port_six_direction;
    logic clock_mode_locked, next_clock_mode_locked;
    logic next_oscillator_select, next_external_clock_select;

    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_rvalid, next_awready, next_wready, next_arready;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    logic [P3_W-1:0] next_p3_out, next_p3_oe, next_p3_pu;
    logic next_p4_out, next_p4_oe, next_p4_pu, next_tool_in;
    logic [P6_W-1:0] next_p6_out, next_p6_oe;
    logic next_irq;

    logic [SYNC_W-1:0] pins_sync;
    logic [P3_W-1:0] p3_pin;
    logic p4_pin, tool_att, p13_pin;
    logic [P6_W-1:0] p6_pin;
    logic [1:0] p12_pin;
    logic do_write;
    logic [P3_W-1:0] p3_read;
    logic [P6_W-1:0] p6_read;
    logic p4_read;
    logic [1:0] p12_read;

    gpt_sync #(.W(SYNC_W)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({port_three_in, tool_data_pin_in, tool_attached, port_six_in,
                   osc_out_pin, osc_in_pin, interrupt_input_pin}),
        .sync_out(pins_sync)
    );
    assign {p3_pin, p4_pin, tool_att, p6_pin, p12_pin, p13_pin} = pins_sync;

    // read path: pin level for inputs, latch for outputs
    assign p3_read = (port_three_direction & p3_pin) | (~port_three_direction & port_three_data); // [RULE19]
    assign p4_read = port_four_direction[0] ? p4_pin : port_four_data[0]; // [RULE19]
    assign p6_read = (port_six_direction & p6_pin) | (~port_six_direction & port_six_data); // [RULE19]
    // pins given to the oscillator read as zero
    assign p12_read[0] = p12_pin[0] & (~oscillator_select | external_clock_select); // [RULE14]
    assign p12_read[1] = p12_pin[1] & ~oscillator_select; // [RULE14]

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_awready = 1'b0;
        next_wready = 1'b0;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_arready = 1'b0;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_port_three_data = port_three_data;
        next_port_three_direction = port_three_direction;
        next_port_three_pullup_option = port_three_pullup_option;
        next_port_four_data = port_four_data;
        next_port_four_direction = port_four_direction;
        next_port_four_pullup_option = port_four_pullup_option;
        next_port_six_data = port_six_data;
        next_port_six_direction = port_six_direction;
        next_oscillator_select = oscillator_select;
        next_external_clock_select = external_clock_select;
        next_clock_mode_locked = clock_mode_locked;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (!aw_held && !s_axi_awready && !(s_axi_awvalid && s_axi_awready))
            next_awready = s_axi_awvalid;
        if (!w_held && !s_axi_wready && !(s_axi_wvalid && s_axi_wready))
            next_wready = s_axi_wvalid;
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            if (w_strb[0])
            begin
                case (aw_addr)
                    OFS_P3_DATA: next_port_three_data = w_data[P3_W-1:0]; // [RULE20]
                    OFS_P3_DIR: next_port_three_direction = w_data[P3_W-1:0]; // [RULE1]
                    OFS_P3_PU: next_port_three_pullup_option = w_data[P3_W-1:0]; // [RULE2]
                    OFS_P4_DATA: next_port_four_data = w_data[P4_W-1:0]; // [RULE20]
                    OFS_P4_DIR: next_port_four_direction = w_data[P4_W-1:0]; // [RULE7]
                    OFS_P4_PU: next_port_four_pullup_option = w_data[P4_W-1:0]; // [RULE7]
                    OFS_P6_DATA: next_port_six_data = w_data[P6_W-1:0]; // [RULE20]
                    OFS_P6_DIR: next_port_six_direction = w_data[P6_W-1:0]; // [RULE11]
                    OFS_CLK_MODE:
                    begin
                        // first write after reset sticks, later ones ignored
                        if (!clock_mode_locked) // [RULE15]
                        begin
                            next_oscillator_select = w_data[CLK_MODE_OSC_BIT]; // [RULE16]
                            next_external_clock_select = w_data[CLK_MODE_EXT_BIT];
                            next_clock_mode_locked = 1'b1; // [RULE15]
                        end
                    end
                    OFS_P12_DATA, OFS_P13_DATA: next_bresp = RESP_SLVERR; // [RULE13]
                    default: next_bresp = RESP_SLVERR;
                endcase
            end
            else if (!(aw_addr inside {OFS_P3_DATA, OFS_P3_DIR, OFS_P3_PU, OFS_P4_DATA, OFS_P4_DIR,
                                      OFS_P4_PU, OFS_P6_DATA, OFS_P6_DIR, OFS_CLK_MODE}))
                next_bresp = RESP_SLVERR;
        end
        if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
        begin
            next_arready = 1'b1;
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0000_0000;
            case (s_axi_araddr)
                OFS_P3_DATA: next_rdata[P3_W-1:0] = p3_read;
                OFS_P3_DIR: next_rdata[P3_W-1:0] = port_three_direction;
                OFS_P3_PU: next_rdata[P3_W-1:0] = port_three_pullup_option;
                OFS_P4_DATA: next_rdata[0] = p4_read;
                OFS_P4_DIR: next_rdata[P4_W-1:0] = port_four_direction;
                OFS_P4_PU: next_rdata[P4_W-1:0] = port_four_pullup_option;
                OFS_P6_DATA: next_rdata[P6_W-1:0] = p6_read;
                OFS_P6_DIR: next_rdata[P6_W-1:0] = port_six_direction;
                OFS_P12_DATA: next_rdata[2:1] = p12_read; // [RULE14]
                OFS_CLK_MODE: next_rdata[2:0] = {clock_mode_locked, external_clock_select, oscillator_select};
                OFS_P13_DATA: next_rdata[P13_PIN_BIT] = p13_pin; // [RULE18]
                default: next_rresp = RESP_SLVERR;
            endcase
        end
    end

    // pin drive
    always_comb
    begin
        next_p3_oe = ~port_three_direction; // [RULE1]
        next_p3_out = port_three_data; // [RULE1]
        next_p3_pu = port_three_direction & port_three_pullup_option; // [RULE2]
        if (tool_att) // [RULE9]
        begin
            next_p4_out = tool_data_out;
            next_p4_oe = tool_data_oe;
            next_p4_pu = 1'b0;
        end
        else
        begin
            next_p4_out = port_four_data[0]; // [RULE7]
            next_p4_oe = ~port_four_direction[0];
            next_p4_pu = port_four_direction[0] & port_four_pullup_option[0]; // [RULE7]
        end
        next_tool_in = tool_att & p4_pin;
        next_p6_out = '0; // [RULE10]
        next_p6_oe = ~port_six_direction & ~port_six_data; // [RULE10]
        next_irq = p13_pin; // [RULE18]
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            port_three_data <= '0;
            port_three_direction <= P3_DIR_RST; // [RULE3]
            port_three_pullup_option <= '0;
            port_four_data <= '0;
            port_four_direction <= P4_DIR_RST; // [RULE8]
            port_four_pullup_option <= '0;
            port_six_data <= '0;
            port_six_direction <= P6_DIR_RST; // [RULE11]
            oscillator_select <= 1'b0; // [RULE17]
            external_clock_select <= 1'b0;
            clock_mode_locked <= 1'b0;
            port_three_out <= '0;
            port_three_oe <= '0;
            port_three_pullup_en <= '0;
            tool_data_pin_out <= 1'b0;
            tool_data_pin_oe <= 1'b0;
            tool_data_pin_pullup_en <= 1'b0;
            tool_data_in <= 1'b0;
            port_six_out <= '0;
            port_six_oe <= '0;
            interrupt_request <= 1'b0;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            port_three_data <= next_port_three_data;
            port_three_direction <= next_port_three_direction;
            port_three_pullup_option <= next_port_three_pullup_option;
            port_four_data <= next_port_four_data;
            port_four_direction <= next_port_four_direction;
            port_four_pullup_option <= next_port_four_pullup_option;
            port_six_data <= next_port_six_data;
            port_six_direction <= next_port_six_direction;
            oscillator_select <= next_oscillator_select;
            external_clock_select <= next_external_clock_select;
            clock_mode_locked <= next_clock_mode_locked;
            port_three_out <= next_p3_out;
            port_three_oe <= next_p3_oe;
            port_three_pullup_en <= next_p3_pu;
            tool_data_pin_out <= next_p4_out;
            tool_data_pin_oe <= next_p4_oe;
            tool_data_pin_pullup_en <= next_p4_pu;
            tool_data_in <= next_tool_in;
            port_six_out <= next_p6_out;
            port_six_oe <= next_p6_oe;
            interrupt_request <= next_irq;
        end
    end
endmodule // gpt_ports
`default_nettype wire

// ### verilog/gpt_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to aclk
`timescale 1ns/1ns
`default_nettype none
module gpt_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stage1 <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // gpt_sync
`default_nettype wire
